// ===== design/tw_pkg.sv
// Constants for the timer, shared prescaler and watchdog block
package tw_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TW_OFS_SETUP   = 8'h00;
  localparam logic [7:0] TW_OFS_COUNT   = 8'h04;
  localparam logic [7:0] TW_OFS_CMP     = 8'h08;
  localparam logic [7:0] TW_OFS_STATUS  = 8'h0c;
  localparam logic [7:0] TW_OFS_CMD     = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TW_RATIO_LSB      = 0;
  localparam int TW_RATIO_W        = 3;
  localparam int TW_BIT_PS_ASSIGN  = 3;
  localparam int TW_BIT_EDGE_SEL   = 4;
  localparam int TW_BIT_SRC_SEL    = 5;
  localparam int TW_BIT_CMP_SEL    = 4;
  localparam int TW_BIT_CMP_INHIB  = 6;
  localparam int TW_BIT_PD_N       = 3;
  localparam int TW_BIT_TO_N       = 4;
  localparam int TW_BIT_CMD_WATCHDOG_CLEAR_INSTR = 0;
  localparam int TW_BIT_CMD_SLEEP  = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] TW_SETUP_RST   = 6'h3f;
  localparam logic [7:0] TW_COUNT_RST   = 8'h00;
  localparam logic       TW_CMP_SEL_RST = 1'b1;
  localparam logic       TW_INHIB_RST   = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TW_CLK_PERIOD_NS   = 50;
  localparam int TW_INSTR_CYCLE_NS  = 1000;
  localparam int TW_INSTR_CLKS      = TW_INSTR_CYCLE_NS / TW_CLK_PERIOD_NS;
  localparam int TW_WDT_PERIOD_MS   = 18;
  localparam int TW_WDT_PERIOD_CLKS = TW_WDT_PERIOD_MS * 1000000 / TW_CLK_PERIOD_NS;
  localparam logic [1:0] TW_WR_INHIBIT = 2'h2;

  // Power state of the device core
  typedef enum logic {TW_RUN, TW_SLEEP} tw_power_e;
endpackage

// ===== design/tw_wdt_base.sv
// Watchdog base period generator standing for the free-running RC oscillator
`timescale 1ns/10ps
`default_nettype none
module tw_wdt_base #(
  parameter int PERIOD_CLKS = 360000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clear,
  output logic      tick_q
);
  localparam int CW = $clog2(PERIOD_CLKS + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CLKS - 1);

  logic [CW-1:0] cnt_q;

  // Base counter, never gated by sleep; cleared on request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (clear)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== design/tw_timer_watchdog.sv
// Timer/counter with shared prescaler and watchdog, APB register slave
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module tw_timer_watchdog #(
  parameter int ADDR_W          = 8,
  parameter int WDT_PERIOD_CLKS = tw_pkg::TW_WDT_PERIOD_CLKS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              external_count_input,
  input  wire logic              comparator_out,
  input  wire logic              watchdog_fuse_enable,
  input  wire logic              wake_event,
  output logic                   comparator_output_pin_q,
  output logic                   comparator_output_pin_oe_n_q,
  output logic                   device_reset_q,
  output logic                   osc_off_q,
  output logic      [7:0]        timer_count_register
);
  import tw_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [5:0]  setup_q;
  logic [7:0]  count_q;
  logic        cmp_sel_q;
  logic        cmp_inhib_q;
  logic        to_n_q;
  logic        pd_n_q;
  logic [7:0]  ps_q;
  logic [1:0]  inhibit_q;
  logic [4:0]  instr_div_q;
  logic        ext_prev_q;
  logic        cmp_prev_q;
  tw_power_e   power_q;
  logic        wdt_tick;
  logic        wr_en;
  logic        rd_setup;
  logic        apb_hit;
  logic [2:0]  ratio;
  logic        ps_to_wdt;
  logic        instr_tick;
  logic        src_level;
  logic        src_prev;
  logic        src_edge;
  logic        cnt_event;
  logic        ps_event;
  logic [7:0]  ps_mask;
  logic        ps_hit;
  logic        cnt_inc;
  logic        wdt_timeout;
  logic        cmd_watchdog_clear_instr;
  logic        cmd_sleep;
  logic        wake;
  logic        wdt_clear;
  logic        count_wr;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign rd_setup   = psel && !penable && !pready;
  assign wr_en      = psel && penable && pready && pwrite && !pslverr;
  assign apb_hit    = (paddr[7:0] == TW_OFS_SETUP) || (paddr[7:0] == TW_OFS_COUNT) ||
                      (paddr[7:0] == TW_OFS_CMP) || (paddr[7:0] == TW_OFS_STATUS) ||
                      (paddr[7:0] == TW_OFS_CMD);
  assign count_wr   = wr_en && (paddr[7:0] == TW_OFS_COUNT);
  assign cmd_watchdog_clear_instr = wr_en && (paddr[7:0] == TW_OFS_CMD) && pwdata[TW_BIT_CMD_WATCHDOG_CLEAR_INSTR];
  assign cmd_sleep  = wr_en && (paddr[7:0] == TW_OFS_CMD) && pwdata[TW_BIT_CMD_SLEEP]
                      && (power_q == TW_RUN);

  // Answer one cycle after setup, read data sampled at setup
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= rd_setup;
      pslverr <= rd_setup && !apb_hit;
      if (rd_setup && !pwrite)
      begin
        unique case (paddr[7:0])
          TW_OFS_SETUP:  prdata <= {26'h0, setup_q};
          TW_OFS_COUNT:  prdata <= {24'h0, count_q};
          TW_OFS_CMP:    prdata <= {25'h0, cmp_inhib_q, 1'b0, cmp_sel_q, 4'h0};
          TW_OFS_STATUS: prdata <= {27'h0, to_n_q, pd_n_q, 3'h0};
          default:       prdata <= '0; // Prescaler has no address
        endcase
      end
      else
      begin
        prdata <= '0;
      end
    end
  end

  // Setup and comparator control registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      setup_q     <= TW_SETUP_RST;
      cmp_sel_q   <= TW_CMP_SEL_RST;
      cmp_inhib_q <= TW_INHIB_RST;
    end
    else if (wr_en)
    begin
      if (paddr[7:0] == TW_OFS_SETUP)
        setup_q <= pwdata[5:0];
      if (paddr[7:0] == TW_OFS_CMP)
      begin
        cmp_sel_q   <= pwdata[TW_BIT_CMP_SEL];
        cmp_inhib_q <= pwdata[TW_BIT_CMP_INHIB];
      end
    end
  end

  // ----------------------------------------------------------------
  // Count source selection
  // ----------------------------------------------------------------
  assign ratio     = setup_q[TW_RATIO_LSB +: TW_RATIO_W];
  assign ps_to_wdt = setup_q[TW_BIT_PS_ASSIGN];

  // Instruction cycle strobe, stops with the main oscillator
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      instr_div_q <= '0;
    else if (power_q == TW_SLEEP || instr_div_q == 5'(TW_INSTR_CLKS - 1))
      instr_div_q <= '0;
    else
      instr_div_q <= instr_div_q + 1'b1;
  end
  assign instr_tick = (instr_div_q == 5'(TW_INSTR_CLKS - 1)) && (power_q == TW_RUN);

  // Previous levels for edge detection
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_prev_q <= 1'b0;
      cmp_prev_q <= 1'b0;
    end
    else
    begin
      ext_prev_q <= external_count_input;
      cmp_prev_q <= comparator_out;
    end
  end

  // Internal comparator path or pin path, both edge selected
  always_comb
  begin
    if (!cmp_sel_q)
    begin
      src_level = comparator_out;
      src_prev  = cmp_prev_q;
    end
    else
    begin
      src_level = external_count_input;
      src_prev  = ext_prev_q;
    end
    if (setup_q[TW_BIT_EDGE_SEL])
      src_edge = src_prev && !src_level;
    else
      src_edge = !src_prev && src_level;
  end

  assign cnt_event = setup_q[TW_BIT_SRC_SEL] ? (src_edge && power_q == TW_RUN)
                                             : instr_tick;

  // ----------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------
  assign ps_event = ps_to_wdt ? (wdt_tick && watchdog_fuse_enable) : cnt_event;

  // Mask width is n+1 bits for counter, n bits for watchdog
  assign ps_mask = ps_to_wdt ? 8'((9'h1 << ratio) - 9'h1)
                             : 8'((9'h2 << ratio) - 9'h1);
  assign ps_hit  = ((ps_q & ps_mask) == ps_mask);

  assign wake      = (power_q == TW_SLEEP) && (wake_event || wdt_timeout);
  assign wdt_clear = cmd_watchdog_clear_instr || cmd_sleep || wake;

  // Prescaler count, cleared with the watchdog when assigned to it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ps_q <= '0;
    else if (ps_to_wdt && wdt_clear)
      ps_q <= '0;
    else if (ps_event)
      ps_q <= ps_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // Counter register
  // ----------------------------------------------------------------
  assign cnt_inc = cnt_event && (ps_to_wdt || ps_hit) && (inhibit_q == 2'h0);

  // Two instruction cycles of hold-off after a counter write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      inhibit_q <= '0;
    else if (count_wr)
      inhibit_q <= TW_WR_INHIBIT;
    else if (instr_tick && inhibit_q != 2'h0)
      inhibit_q <= inhibit_q - 1'b1;
  end

  // Counter, software write wins over an increment
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q              <= TW_COUNT_RST;
      timer_count_register <= TW_COUNT_RST;
    end
    else if (count_wr)
    begin
      count_q              <= pwdata[7:0];
      timer_count_register <= pwdata[7:0];
    end
    else if (cnt_inc)
    begin
      count_q              <= count_q + 1'b1;
      timer_count_register <= count_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Comparator pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      comparator_output_pin_q      <= 1'b0;
      comparator_output_pin_oe_n_q <= 1'b1;
    end
    else
    begin
      comparator_output_pin_q      <= comparator_out;
      comparator_output_pin_oe_n_q <= !(setup_q[TW_BIT_SRC_SEL] && cmp_sel_q
                                        && !cmp_inhib_q);
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  tw_wdt_base #(
    .PERIOD_CLKS (WDT_PERIOD_CLKS)
  ) u_wdt_base (
    .clk    (clk),
    .rst    (rst),
    .clear  (wdt_clear || !watchdog_fuse_enable),
    .tick_q (wdt_tick)
  );

  // Only the commands suppress a time-out; a wake must not feed back into it
  assign wdt_timeout = watchdog_fuse_enable && wdt_tick && !(cmd_watchdog_clear_instr || cmd_sleep)
                       && (!ps_to_wdt || ps_hit);

  // Power state and oscillator driver
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      power_q   <= TW_RUN;
      osc_off_q <= 1'b0;
    end
    else if (cmd_sleep)
    begin
      power_q   <= TW_SLEEP;
      osc_off_q <= 1'b1;
    end
    else if (wake)
    begin
      power_q   <= TW_RUN;
      osc_off_q <= 1'b0;
    end
  end

  // Device reset pulse on time-out
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      device_reset_q <= 1'b0;
    else
      device_reset_q <= wdt_timeout;
  end

  // Status flags, a clear command wins over a hardware time-out in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
    end
    else if (wdt_timeout)
      to_n_q <= 1'b0;
    else if (cmd_sleep)
    begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b0;
    end
    else if (cmd_watchdog_clear_instr)
    begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_WRITE_LOADS: assert property (@(posedge clk) disable iff (rst)
    count_wr |=> count_q == $past(pwdata[7:0])) else $error("Counter write lost");
  AST_TIMER_STEP: assert property (@(posedge clk) disable iff (rst)
    (instr_tick && !setup_q[TW_BIT_SRC_SEL] && ps_to_wdt && inhibit_q == 2'h0 && !count_wr)
    |=> count_q == $past(count_q) + 8'h01) else $error("Timer did not step");
  AST_WRITE_HOLD: assert property (@(posedge clk) disable iff (rst)
    count_wr |=> (inhibit_q == TW_WR_INHIBIT) && !cnt_inc) else $error("No hold-off");
  AST_EDGE_ONLY: assert property (@(posedge clk) disable iff (rst)
    (setup_q[TW_BIT_SRC_SEL] && !src_edge && !count_wr) |=> $stable(count_q))
    else $error("Counter moved without edge");
  AST_PS_EXCL: assert property (@(posedge clk) disable iff (rst)
    (ps_to_wdt && !count_wr && cnt_event && inhibit_q == 2'h0) |=> count_q != $past(count_q))
    else $error("Counter stalled while prescaler at watchdog");
  AST_PIN_DRIVE: assert property (@(posedge clk) disable iff (rst)
    (setup_q[TW_BIT_SRC_SEL] && cmp_sel_q && !cmp_inhib_q) |=> !comparator_output_pin_oe_n_q)
    else $error("Comparator not driven to pin");
  AST_FUSE_OFF: assert property (@(posedge clk) disable iff (rst)
    !watchdog_fuse_enable |-> !wdt_timeout) else $error("Time-out with fuse off");
  AST_TO_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wdt_timeout |=> !to_n_q && device_reset_q) else $error("Time-out flag not cleared");
  AST_SLEEP_FLAGS: assert property (@(posedge clk) disable iff (rst)
    (cmd_sleep && !wdt_timeout) |=> to_n_q && !pd_n_q && osc_off_q)
    else $error("Sleep flags wrong");
  AST_WAKE_CLR: assert property (@(posedge clk) disable iff (rst)
    wake |=> !wdt_tick ##1 !wdt_tick) else $error("Watchdog not cleared on wake");
  AST_NO_SLEEP_TICK: assert property (@(posedge clk) disable iff (rst)
    (power_q == TW_SLEEP) |-> !instr_tick) else $error("Instruction clock in sleep");

  COV_WRAP: cover property (@(posedge clk) disable iff (rst)
    cnt_inc && count_q == 8'hff);
  COV_SLEEP_WAKE: cover property (@(posedge clk) disable iff (rst)
    cmd_sleep ##[1:1000] wake);
  COV_TIMEOUT: cover property (@(posedge clk) disable iff (rst) wdt_timeout);
endmodule
`default_nettype wire

// ===== sim/tw_count_source.sv
// Model of the external count pin driver and the on-chip comparator
`timescale 1ns/10ps
`default_nettype none
module tw_count_source (
  input  wire logic clk,
  input  wire logic pin_from_dev,
  input  wire logic pin_oe_n,
  output logic      pin_level,
  output logic      cmp_level
);
  logic ext_q;

  // Pin wire: the block owns it while its enable is low
  assign pin_level = pin_oe_n ? ext_q : pin_from_dev;

  // Both sources idle low
  initial
  begin
    ext_q = 1'b0;
    cmp_level = 1'b0;
  end

  // Move one source to a new level just after a clock edge
  task automatic drive(input bit use_cmp, input logic lvl);
    @(posedge clk);
    if (use_cmp)
      cmp_level <= lvl;
    else
      ext_q <= lvl;
  endtask
endmodule
`default_nettype wire

// ===== sim/timer_watchdog_shared_prescaler_bench.sv
// Register-level bench for the timer, shared prescaler and watchdog
`timescale 1ns/10ps
`default_nettype none
module timer_watchdog_shared_prescaler_bench;
  import tw_pkg::*;
  localparam int WDT_CLKS = 50;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        cmp;
  logic        fuse;
  logic        wake;
  logic        pin_q;
  logic        oe_n;
  logic        dev_rst;
  logic        osc_off;
  logic [7:0]  count;
  logic [31:0] rd;
  logic        se;
  int          err_total;
  int          samples_checked;
  int          n;
  int          i;
  bit          use_cmp;

  // ----
  // Design and far-side model
  // ----
  tw_timer_watchdog #(.ADDR_W(8), .WDT_PERIOD_CLKS(WDT_CLKS)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_input(pin), .comparator_out(cmp),
    .watchdog_fuse_enable(fuse), .wake_event(wake),
    .comparator_output_pin_q(pin_q), .comparator_output_pin_oe_n_q(oe_n),
    .device_reset_q(dev_rst), .osc_off_q(osc_off), .timer_count_register(count)
  );
  tw_count_source src (
    .clk(clk), .pin_from_dev(pin_q), .pin_oe_n(oe_n),
    .pin_level(pin), .cmp_level(cmp)
  );

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
      if (k > 20)
      begin
        err_total++;
        test_done();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles until the counter moves; a hang ends the run
  task automatic wait_change(input int lim, output int cyc);
    logic [7:0] old;
    @(posedge clk);
    old = count;
    cyc = 1;
    do
    begin
      @(posedge clk);
      cyc++;
      if (cyc > lim)
      begin
        err_total++;
        test_done();
      end
    end while (count === old);
  endtask

  // Cycles until a device reset pulse, lim+1 if none came
  task automatic wait_rst(input int lim, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
    end while (dev_rst !== 1'b1 && cyc <= lim);
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fuse = 1'b0;
    wake = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped word
    apb(1'b0, TW_OFS_SETUP, 32'h0);
    check("setup reset", rd, 32'h3f);
    apb(1'b0, TW_OFS_CMP, 32'h0);
    check("compare reset", rd, 32'h50);
    apb(1'b0, TW_OFS_STATUS, 32'h0);
    check("status reset", rd, 32'h18);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped error", {31'h0, se}, 32'h1);
    // Timer mode: write inhibit, tick rate, wrap
    apb(1'b1, TW_OFS_SETUP, 32'h08);
    apb(1'b1, TW_OFS_COUNT, 32'hfe);
    wait_change(100, n);
    check("inhibit window", n > 40 && n <= 62, 1);
    check("count after write", count, 8'hff);
    wait_change(30, n);
    check("tick period", n, 20);
    check("wrap", count, 8'h00);
    // Every counter prescale ratio
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, TW_OFS_SETUP, i);
      wait_change(6000, n);
      wait_change(6000, n);
      check("prescaled period", n, 20 << (i + 1));
    end
    // Edge counting: pin, internal comparator, comparator through pin
    for (i = 0; i < 6; i++)
    begin
      use_cmp = (i % 3 != 0);
      apb(1'b1, TW_OFS_CMP, (i % 3 == 0) ? 32'h50 : ((i % 3 == 1) ? 32'h0 : 32'h10));
      apb(1'b1, TW_OFS_SETUP, 32'h28 | ((i / 3) << 4));
      apb(1'b1, TW_OFS_COUNT, 32'h0);
      repeat (60) @(posedge clk);
      check("pin enable", oe_n, (i % 3 == 2) ? 0 : 1);
      src.drive(use_cmp, 1'b1);
      repeat (4) @(posedge clk);
      check("count after rise", count, (i < 3) ? 1 : 0);
      src.drive(use_cmp, 1'b0);
      repeat (4) @(posedge clk);
      check("count after fall", count, 1);
      src.drive(!use_cmp, 1'b1);
      src.drive(!use_cmp, 1'b0);
      repeat (4) @(posedge clk);
      check("other source", count, 1);
    end
    apb(1'b0, TW_OFS_COUNT, 32'h0);
    check("count readback", rd, 32'h1);
    // Watchdog: fuse, base period, prescaled period
    apb(1'b1, TW_OFS_SETUP, 32'h08);
    wait_rst(300, n);
    check("fuse off", n, 301);
    fuse <= 1'b1;
    apb(1'b1, TW_OFS_CMD, 32'h1);
    wait_rst(80, n);
    check("base timeout", n >= 49 && n <= 53, 1);
    apb(1'b0, TW_OFS_STATUS, 32'h0);
    check("status after timeout", rd, 32'h08);
    apb(1'b1, TW_OFS_SETUP, 32'h0a);
    apb(1'b1, TW_OFS_CMD, 32'h1);
    wait_rst(260, n);
    check("prescaled timeout", n >= 196 && n <= 206, 1);
    // Periodic clear keeps the watchdog quiet
    apb(1'b1, TW_OFS_SETUP, 32'h08);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b1, TW_OFS_CMD, 32'h1);
      wait_rst(30, n);
      check("cleared in time", n, 31);
    end
    apb(1'b0, TW_OFS_STATUS, 32'h0);
    check("status after clear", rd, 32'h18);
    // Sleep, wake by event, then wake by time-out
    apb(1'b1, TW_OFS_SETUP, 32'h0a);
    apb(1'b1, TW_OFS_CMD, 32'h2);
    apb(1'b0, TW_OFS_STATUS, 32'h0);
    check("status asleep", rd, 32'h10);
    check("osc off", osc_off, 1);
    // Wake well after sleep so a missed clear would time out early
    repeat (100) @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_rst(260, n);
    check("wdt cleared on wake", n >= 194 && n <= 206, 1);
    check("osc on", osc_off, 0);
    apb(1'b1, TW_OFS_CMD, 32'h2);
    wait_rst(260, n);
    check("sleep timeout", n >= 196 && n <= 206, 1);
    repeat (3) @(posedge clk);
    check("osc on after wake", osc_off, 0);
    apb(1'b0, TW_OFS_STATUS, 32'h0);
    check("status wdt wake", rd, 32'h00);
    test_done();
  end
endmodule
`default_nettype wire
